//--- verilog/mfg_map.svh
// Constants for the motor fault guard and torque command front end
`ifndef MFG_MAP_SVH
`define MFG_MAP_SVH
`define MFG_SPEED_MAX_RPS 12'h0960
`define MFG_TEMP_MIN_C 10'sh3CE
`define MFG_TEMP_MAX_C 10'sh1F4
`define MFG_PCT_MAX 7'h64
`define MFG_CUR_MAX_A 11'sh3E8
`define MFG_TRACE_DEPTH 9
`define MFG_FRAME_ID 11'h111
`define MFG_RIDE_MODE_DEF 2'h2
`define MFG_ACT_MODE_CAN 3'h1
`define MFG_FC_NONE 32'h0000_0000
`define MFG_FC_SPEED 32'h0000_0001
`define MFG_FC_TEMP 32'h0000_0002
`define MFG_FC_BOTH 32'h0000_0003
`define MFG_ASC_TIME_US 1000
`define MFG_CLK_MHZ 25
`define MFG_ASC_CYCLES ((`MFG_ASC_TIME_US) * (`MFG_CLK_MHZ))
`define MFG_ODO_MAX 32'h17D7_8400
`define MFG_KBPS_125 20'h0_007D
`define MFG_KBPS_500 20'h0_01F4
`define MFG_KBPS_1000 20'h0_03E8
`endif

//--- verilog/mfg_pkg.sv
// Types shared by the motor fault guard files
package mfg_pkg;
  typedef enum logic [2:0] {
    MFG_SRC_NONE, MFG_SRC_AIN_ONE, MFG_SRC_AIN_TWO, MFG_SRC_PWM_DIN_TWO, MFG_SRC_CAN, MFG_SRC_USB
  } mfg_src_t;
  typedef enum logic [1:0] {MFG_BAUD_OFF, MFG_BAUD_125K, MFG_BAUD_500K, MFG_BAUD_1000K} mfg_baud_t;
  typedef struct packed {
    logic [10:0] id;
    logic [6:0] torque_pct;
    logic [1:0] ride_mode;
    logic state_req;
  } mfg_frame_t;
  typedef struct packed {
    logic signed [10:0] field_a;
    logic signed [10:0] active_a;
  } mfg_setpoint_t;
endpackage : mfg_pkg

//--- verilog/mfg_trace.sv
// Nine-entry fault history with odometer stamps
`include "mfg_map.svh"
module mfg_trace #(
  parameter int DEPTH = `MFG_TRACE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic push,
  input wire logic [31:0] code,
  input wire logic [31:0] odo,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_code,
  output logic [31:0] rd_odo
);
  logic [31:0] code_r [DEPTH];
  logic [31:0] odo_r [DEPTH];

  // Shift register: entry 0 is the newest, survives fault clearing
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          code_r[g] <= `MFG_FC_NONE;
          odo_r[g] <= 32'h0000_0000;
        end else if (push) begin
          code_r[g] <= (g == 0) ? code : code_r[(g == 0) ? 0 : g - 1]; // [RULE6]
          odo_r[g] <= (g == 0) ? odo : odo_r[(g == 0) ? 0 : g - 1]; // [RULE7]
        end
      end
    end
  endgenerate

  // Registered read port; out-of-range index reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_code <= `MFG_FC_NONE;
      rd_odo <= 32'h0000_0000;
    end else if (32'(rd_idx) < DEPTH) begin
      rd_code <= code_r[rd_idx]; // [RULE6]
      rd_odo <= odo_r[rd_idx]; // [RULE7]
    end else begin
      rd_code <= `MFG_FC_NONE;
      rd_odo <= 32'h0000_0000;
    end
  end
endmodule : mfg_trace

//--- verilog/mfg_guard.sv
// Limit guard, active short circuit, fault trace and torque path
`include "mfg_map.svh"
// How it works
// RULE1: Limit breach forces active short circuit quickly
// RULE2: Power stage stays off until fault removed
// RULE3: Active fault reported as 32-bit code
// RULE4: Speed limit 0..2400 rps stops system
// RULE5: Temperature limit -50..500 C stops system
// RULE6: Nine newest fault codes kept, index 0..8
// RULE7: Odometer stamp stored beside each code
// RULE8: Torque: coordinate, then limit, then convert
// RULE9: Gear 0 forward, 1 reverse, USB only
// RULE10: Manual percent of max torque, USB only
// RULE11: Field and active setpoints within 1000 A
// RULE12: Source codes: none, analog one/two, PWM, CAN, USB
// RULE13: Activation mode 1 enables CAN state request
// RULE14: Baud select 1/2/3 = 125/500/1000 kbit/s
// RULE15: Command frame id 0x111, torque percent
// RULE16: Frame ride mode 0..3, normally 2
// RULE17: State request rising edge activates CAN control
// RULE18: Latched fault zeroes setpoints, ignores requests; a CAN state request still raises external_activation_request during a fault
module mfg_guard #(
  parameter int ASC_CYCLES = `MFG_ASC_CYCLES,
  parameter logic [11:0] SPEED_LIMIT_DEF = `MFG_SPEED_MAX_RPS,
  parameter logic signed [9:0] TEMP_LIMIT_DEF = `MFG_TEMP_MAX_C
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [11:0] speed_limit_cfg,
  input wire logic signed [9:0] temp_limit_cfg,
  input wire logic [11:0] rotor_speed,
  input wire logic signed [9:0] motor_temp,
  input wire logic [31:0] odometer,
  input wire logic fault_clear,
  input wire logic [2:0] torque_source_cfg,
  input wire logic [2:0] gear_source_cfg,
  input wire logic [2:0] activation_source_cfg,
  input wire logic [1:0] baud_select_cfg,
  input wire logic [6:0] manual_torque_percent,
  input wire logic manual_gear_select,
  input wire logic [6:0] analog_input_one,
  input wire logic [6:0] analog_input_two,
  input wire logic [6:0] digital_input_two,
  input wire logic [6:0] ride_mode_cfg,
  input wire logic signed [10:0] max_torque_current,
  input wire logic frame_valid,
  input wire mfg_pkg::mfg_frame_t torque_command_frame,
  input wire logic [3:0] trace_index,
  output logic asc_active,
  output logic power_enable,
  output logic [31:0] active_fault_code,
  output logic [31:0] trace_code,
  output logic [31:0] trace_odometer,
  output logic [19:0] can_bit_rate_kbps,
  output logic external_activation_request,
  output logic [1:0] frame_ride_mode,
  output mfg_pkg::mfg_setpoint_t current_setpoint,
  output logic reverse_active
);
  localparam int ASC_W = $clog2(ASC_CYCLES + 1);

  logic [31:0] fault_r;
  logic [ASC_W-1:0] asc_cnt_r;
  logic [6:0] frame_pct_r;
  logic state_req_prev_r;
  logic [6:0] des_pct_r;
  logic des_rev_r;
  logic [6:0] lim_pct_r;
  logic lim_rev_r;
  logic over_speed;
  logic over_temp;
  logic [31:0] new_code;
  logic push;
  logic [11:0] spd_lim;
  logic signed [9:0] tmp_lim;
  logic [6:0] sel_pct;
  logic signed [18:0] prod;
  logic signed [10:0] iq_mag;

  // Clamp a percent to 0..100
  function automatic logic [6:0] mfg_clip_pct(input logic [6:0] v);
    return (v > `MFG_PCT_MAX) ? `MFG_PCT_MAX : v;
  endfunction : mfg_clip_pct

  // Pick the percent for a channel code; unknown codes give zero
  function automatic logic [6:0] mfg_pick(input logic [2:0] src, input logic [6:0] a1, input logic [6:0] a2,
      input logic [6:0] pw, input logic [6:0] cn, input logic [6:0] us);
    unique case (mfg_pkg::mfg_src_t'(src))
      mfg_pkg::MFG_SRC_AIN_ONE: return a1; // [RULE12]
      mfg_pkg::MFG_SRC_AIN_TWO: return a2;
      mfg_pkg::MFG_SRC_PWM_DIN_TWO: return pw;
      mfg_pkg::MFG_SRC_CAN: return cn;
      mfg_pkg::MFG_SRC_USB: return us;
      default: return 7'h00;
    endcase
  endfunction : mfg_pick

  // Out-of-range limits fall back to the top of the legal range
  assign spd_lim = (speed_limit_cfg > `MFG_SPEED_MAX_RPS) ? SPEED_LIMIT_DEF : speed_limit_cfg; // [RULE4]
  assign tmp_lim = (temp_limit_cfg > `MFG_TEMP_MAX_C || temp_limit_cfg < `MFG_TEMP_MIN_C) ?
      TEMP_LIMIT_DEF : temp_limit_cfg; // [RULE5]
  assign over_speed = rotor_speed > spd_lim; // [RULE4]
  assign over_temp = motor_temp > tmp_lim; // [RULE5]
  assign new_code = over_speed && over_temp ? `MFG_FC_BOTH :
      over_speed ? `MFG_FC_SPEED : over_temp ? `MFG_FC_TEMP : `MFG_FC_NONE;
  // Record only the first code of a new fault so the trace is not flooded
  assign push = (new_code != `MFG_FC_NONE) && (fault_r == `MFG_FC_NONE);

  // Fault latch; a live breach wins over a clear request
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fault_r <= `MFG_FC_NONE;
    end else if (new_code != `MFG_FC_NONE) begin
      fault_r <= fault_r | new_code; // [RULE3]
    end else if (fault_clear) begin
      fault_r <= `MFG_FC_NONE; // [RULE2]
    end
  end

  // Short circuit asserts within ASC_CYCLES; here it rises with the latch, one cycle after the breach
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      asc_cnt_r <= '0;
      asc_active <= 1'b0;
      power_enable <= 1'b0;
      active_fault_code <= `MFG_FC_NONE;
    end else begin
      asc_active <= (fault_r != `MFG_FC_NONE) || push; // [RULE1]
      power_enable <= (fault_r == `MFG_FC_NONE) && !push && (asc_cnt_r == '0); // [RULE2]
      active_fault_code <= fault_r; // [RULE3]
      // Restart holdoff after a fault so the stage does not chatter
      if (fault_r != `MFG_FC_NONE) begin
        asc_cnt_r <= ASC_W'(ASC_CYCLES);
      end else if (asc_cnt_r != '0) begin
        asc_cnt_r <= asc_cnt_r - 1'b1;
      end
    end
  end

  mfg_trace #(
    .DEPTH(`MFG_TRACE_DEPTH)
  ) u_trace (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .push(push),
    .code(new_code),
    .odo((odometer > `MFG_ODO_MAX) ? `MFG_ODO_MAX : odometer),
    .rd_idx(trace_index),
    .rd_code(trace_code),
    .rd_odo(trace_odometer)
  );

  // Command frame intake; other identifiers are ignored
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frame_pct_r <= 7'h00;
      frame_ride_mode <= `MFG_RIDE_MODE_DEF;
      state_req_prev_r <= 1'b0;
      external_activation_request <= 1'b0;
    end else if (frame_valid && torque_command_frame.id == `MFG_FRAME_ID) begin // [RULE15]
      frame_pct_r <= mfg_clip_pct(torque_command_frame.torque_pct); // [RULE15]
      frame_ride_mode <= torque_command_frame.ride_mode; // [RULE16]
      state_req_prev_r <= torque_command_frame.state_req;
      if (torque_command_frame.state_req && !state_req_prev_r &&
          activation_source_cfg == `MFG_ACT_MODE_CAN) begin
        external_activation_request <= 1'b1; // [RULE17] [RULE13]
      end else if (!torque_command_frame.state_req) begin
        external_activation_request <= 1'b0;
      end
    end else if (activation_source_cfg != `MFG_ACT_MODE_CAN) begin
      external_activation_request <= 1'b0; // [RULE13]
    end
  end

  // Bit rate decode, zero for an unused select
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      can_bit_rate_kbps <= 20'h0_0000;
    end else begin
      unique case (mfg_pkg::mfg_baud_t'(baud_select_cfg))
        mfg_pkg::MFG_BAUD_125K: can_bit_rate_kbps <= `MFG_KBPS_125; // [RULE14]
        mfg_pkg::MFG_BAUD_500K: can_bit_rate_kbps <= `MFG_KBPS_500; // [RULE14]
        mfg_pkg::MFG_BAUD_1000K: can_bit_rate_kbps <= `MFG_KBPS_1000; // [RULE14]
        mfg_pkg::MFG_BAUD_OFF: can_bit_rate_kbps <= 20'h0_0000;
      endcase
    end
  end

  // CAN source needs activation; USB uses the manual percent
  assign sel_pct = mfg_pick(torque_source_cfg, analog_input_one, analog_input_two, digital_input_two,
      external_activation_request ? frame_pct_r : 7'h00, manual_torque_percent); // [RULE10] [RULE12]

  // Stage one: coordinate demand and direction
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      des_pct_r <= 7'h00;
      des_rev_r <= 1'b0;
    end else begin
      des_pct_r <= (fault_r != `MFG_FC_NONE) ? 7'h00 : mfg_clip_pct(sel_pct); // [RULE8] [RULE18]
      // Other channels are not modelled, so any source but USB means forward
      if (gear_source_cfg == 3'(mfg_pkg::MFG_SRC_USB)) begin
        des_rev_r <= manual_gear_select; // [RULE9]
      end else begin
        des_rev_r <= 1'b0; // [RULE9]
      end
    end
  end

  // Stage two: limit; ride mode config caps the demand
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lim_pct_r <= 7'h00;
      lim_rev_r <= 1'b0;
    end else begin
      lim_pct_r <= (fault_r != `MFG_FC_NONE) ? 7'h00 :
          (des_pct_r > mfg_clip_pct(ride_mode_cfg) ? mfg_clip_pct(ride_mode_cfg) : des_pct_r); // [RULE8]
      lim_rev_r <= des_rev_r;
    end
  end

  // Stage three: percent of allowed max current, clamped to 1000 A
  assign prod = 19'(max_torque_current < 0 ? 11'sh000 :
      (max_torque_current > `MFG_CUR_MAX_A ? `MFG_CUR_MAX_A : max_torque_current)) * $signed({1'b0, lim_pct_r});
  assign iq_mag = 11'(prod / $signed(19'(`MFG_PCT_MAX)));

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      current_setpoint <= '0;
      reverse_active <= 1'b0;
    end else if (fault_r != `MFG_FC_NONE) begin
      current_setpoint <= '0; // [RULE18]
      reverse_active <= lim_rev_r;
    end else begin
      current_setpoint.field_a <= 11'sh000; // [RULE11]
      current_setpoint.active_a <= lim_rev_r ? -iq_mag : iq_mag; // [RULE8] [RULE11]
      reverse_active <= lim_rev_r;
    end
  end
endmodule : mfg_guard

//--- dv/mfg_guard_asserts.sv
// Port-level assertions for the motor fault guard
module mfg_guard_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [11:0] speed_limit_cfg,
  input wire logic signed [9:0] temp_limit_cfg,
  input wire logic [11:0] rotor_speed,
  input wire logic signed [9:0] motor_temp,
  input wire logic [1:0] baud_select_cfg,
  input wire logic frame_valid,
  input wire mfg_pkg::mfg_frame_t torque_command_frame,
  input wire logic [3:0] trace_index,
  input wire logic asc_active,
  input wire logic power_enable,
  input wire logic [31:0] active_fault_code,
  input wire logic [31:0] trace_code,
  input wire logic [31:0] trace_odometer,
  input wire logic [19:0] can_bit_rate_kbps,
  input wire logic [1:0] frame_ride_mode,
  input wire mfg_pkg::mfg_setpoint_t current_setpoint
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Out-of-range limits are replaced by the default limit in the design, so only in-range ones count here
  wire spd_hit = rotor_speed > speed_limit_cfg && speed_limit_cfg <= 12'h960;
  wire tmp_hit = motor_temp > temp_limit_cfg && temp_limit_cfg >= 10'sh3CE && temp_limit_cfg <= 10'sh1F4;
  wire own_id = torque_command_frame.id == 11'h111;
  function automatic logic [19:0] kbps(input logic [1:0] s);
    return s == 2'h1 ? 20'h7D : s == 2'h2 ? 20'h1F4 : s == 2'h3 ? 20'h3E8 : 20'h0;
  endfunction : kbps
  a_speed_trip: assert property (spd_hit |=> asc_active)
    else $error("speed breach without short circuit");
  a_temp_trip: assert property (tmp_hit |=> asc_active)
    else $error("temperature breach without short circuit");
  a_off_in_fault: assert property (asc_active |-> !power_enable)
    else $error("power stage on during fault");
  a_code_speed: assert property (!asc_active && spd_hit && !tmp_hit |-> ##2 active_fault_code == 32'h1)
    else $error("wrong speed fault code");
  a_zero_in_fault: assert property (asc_active [*2] |-> current_setpoint == '0)
    else $error("setpoint not zero in fault");
  a_amp_range: assert property (current_setpoint.active_a <= 11'sh3E8 && current_setpoint.active_a >= -11'sh3E8
    && current_setpoint.field_a == '0)
    else $error("setpoint out of range");
  a_baud_map: assert property ($past(rst_b) |-> can_bit_rate_kbps == kbps($past(baud_select_cfg)))
    else $error("bit rate mismatch");
  a_trace_range: assert property (trace_index > 4'h8 |=> trace_code == '0 && trace_odometer == '0)
    else $error("trace index past eight not zero");
  a_ride_take: assert property (frame_valid && own_id |=> frame_ride_mode == $past(torque_command_frame.ride_mode))
    else $error("ride mode not taken");
  a_id_filter: assert property (frame_valid && !own_id |=> $stable(frame_ride_mode))
    else $error("foreign frame taken");
  c_trip: cover property ($rose(asc_active));
  c_frame: cover property (frame_valid && own_id);
  c_negative: cover property (current_setpoint.active_a < 0);
endmodule : mfg_guard_asserts

bind mfg_guard mfg_guard_asserts i_mfg_guard_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
  .speed_limit_cfg(speed_limit_cfg), .temp_limit_cfg(temp_limit_cfg), .rotor_speed(rotor_speed),
  .motor_temp(motor_temp), .baud_select_cfg(baud_select_cfg), .frame_valid(frame_valid),
  .torque_command_frame(torque_command_frame), .trace_index(trace_index), .asc_active(asc_active),
  .power_enable(power_enable), .active_fault_code(active_fault_code), .trace_code(trace_code),
  .trace_odometer(trace_odometer), .can_bit_rate_kbps(can_bit_rate_kbps), .frame_ride_mode(frame_ride_mode),
  .current_setpoint(current_setpoint));

//--- dv/mfg_can_host.sv
// CAN host model that sends torque command frames
module mfg_can_host (
  input wire logic clk_sys,
  output logic frame_valid,
  output mfg_pkg::mfg_frame_t torque_command_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_valid = 1'b0;
    torque_command_frame = '1;
  end
  // Between frames the fields show the inverse of the last one, never a stale copy
  task automatic send(input logic [10:0] id, input logic [6:0] pct, input logic [1:0] mode, input logic req);
    @(posedge clk_sys);
    frame_valid <= 1'b1;
    torque_command_frame <= {id, pct, mode, req};
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    torque_command_frame <= ~{id, pct, mode, req};
  endtask : send
endmodule : mfg_can_host

//--- dv/tb_top.sv
// Self-checking bench for the motor fault guard
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_b = 1'b0, fault_clear = 1'b0, manual_gear_select = 1'b0;
  logic [11:0] speed_limit_cfg = 12'h960, rotor_speed = 12'h0;
  logic signed [9:0] temp_limit_cfg = 10'sh064, motor_temp = 10'sh014;
  logic [31:0] odometer = 32'h1234;
  logic [2:0] torque_source_cfg = 3'h5, gear_source_cfg = 3'h5, activation_source_cfg = 3'h1;
  logic [1:0] baud_select_cfg = 2'h1, frame_ride_mode;
  logic [6:0] manual_torque_percent = 7'h32, analog_input_one = 7'h14, analog_input_two = 7'h1E;
  logic [6:0] digital_input_two = 7'h3C, ride_mode_cfg = 7'h64;
  logic signed [10:0] max_torque_current = 11'sh3E8;
  logic [3:0] trace_index = 4'h0;
  logic frame_valid, asc_active, power_enable, external_activation_request, reverse_active;
  mfg_pkg::mfg_frame_t torque_command_frame;
  mfg_pkg::mfg_setpoint_t current_setpoint;
  logic [31:0] active_fault_code, trace_code, trace_odometer;
  logic [19:0] can_bit_rate_kbps;
  logic [31:0] src_exp [4] = '{32'h0, 32'hC8, 32'h12C, 32'h258};
  logic [31:0] kb_exp [4] = '{32'h0, 32'h7D, 32'h1F4, 32'h3E8};
  int miscompares = 0, checks_done = 0;
  always #20 clk_sys = ~clk_sys;
  // Short restart holdoff keeps the run brief
  mfg_guard #(.ASC_CYCLES(8)) i_mfg_guard (.clk_sys(clk_sys), .rst_b(rst_b), .speed_limit_cfg(speed_limit_cfg),
    .temp_limit_cfg(temp_limit_cfg), .rotor_speed(rotor_speed), .motor_temp(motor_temp), .odometer(odometer),
    .fault_clear(fault_clear), .torque_source_cfg(torque_source_cfg), .gear_source_cfg(gear_source_cfg),
    .activation_source_cfg(activation_source_cfg), .baud_select_cfg(baud_select_cfg),
    .manual_torque_percent(manual_torque_percent), .manual_gear_select(manual_gear_select),
    .analog_input_one(analog_input_one), .analog_input_two(analog_input_two), .digital_input_two(digital_input_two),
    .ride_mode_cfg(ride_mode_cfg), .max_torque_current(max_torque_current), .frame_valid(frame_valid),
    .torque_command_frame(torque_command_frame), .trace_index(trace_index), .asc_active(asc_active),
    .power_enable(power_enable), .active_fault_code(active_fault_code), .trace_code(trace_code),
    .trace_odometer(trace_odometer), .can_bit_rate_kbps(can_bit_rate_kbps),
    .external_activation_request(external_activation_request), .frame_ride_mode(frame_ride_mode),
    .current_setpoint(current_setpoint), .reverse_active(reverse_active));
  mfg_can_host i_mfg_can_host (.clk_sys(clk_sys), .frame_valid(frame_valid),
    .torque_command_frame(torque_command_frame));
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Setpoints trail their inputs by three edges; five leaves a margin
  task automatic amp(input logic [31:0] exp);
    step(5);
    @(negedge clk_sys);
    chk(32'(current_setpoint.active_a), exp);
  endtask : amp
  // Bounded wait for the power stage to come back
  task automatic wait_pe;
    for (int i = 0; i < 200 && power_enable !== 1'b1; i++) step(1);
    if (power_enable !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t power stage did not restart", $time);
      report_and_stop();
    end
  endtask : wait_pe
  task automatic rd_trace(input logic [3:0] idx, input logic [31:0] code, input logic [31:0] odo);
    step(1);
    trace_index <= idx;
    step(2);
    @(negedge clk_sys);
    chk(trace_code, code);
    chk(trace_odometer, odo);
  endtask : rd_trace
  initial begin
    step(20);
    chk(active_fault_code, 32'h0);
    chk(32'(power_enable), 32'h0);
    rst_b <= 1'b1;
    wait_pe();
    chk(32'(frame_ride_mode), 32'h2);
    amp(32'h1F4);
    step(1);
    manual_gear_select <= 1'b1;
    amp(32'hFFFF_FE0C);
    chk(32'(reverse_active), 32'h1);
    step(1);
    gear_source_cfg <= 3'h0;
    manual_torque_percent <= 7'h64;
    amp(32'h3E8);
    step(1);
    ride_mode_cfg <= 7'h1E;
    amp(32'h12C);
    step(1);
    ride_mode_cfg <= 7'h64;
    for (int s = 0; s < 4; s++) begin
      step(1);
      torque_source_cfg <= 3'(s);
      amp(src_exp[s]);
    end
    for (int b = 0; b < 4; b++) begin
      step(1);
      baud_select_cfg <= 2'(b);
      step(2);
      @(negedge clk_sys);
      chk(32'(can_bit_rate_kbps), kb_exp[b]);
    end
    step(1);
    torque_source_cfg <= 3'h4;
    i_mfg_can_host.send(11'h112, 7'h28, 2'h3, 1'b1);
    amp(32'h0);
    chk(32'(frame_ride_mode), 32'h2);
    i_mfg_can_host.send(11'h111, 7'h28, 2'h3, 1'b0);
    i_mfg_can_host.send(11'h111, 7'h28, 2'h3, 1'b1);
    amp(32'h190);
    chk(32'(external_activation_request), 32'h1);
    chk(32'(frame_ride_mode), 32'h3);
    i_mfg_can_host.send(11'h111, 7'h28, 2'h0, 1'b0);
    amp(32'h0);
    chk(32'(external_activation_request), 32'h0);
    step(1);
    activation_source_cfg <= 3'h0;
    i_mfg_can_host.send(11'h111, 7'h28, 2'h2, 1'b1);
    amp(32'h0);
    chk(32'(external_activation_request), 32'h0);
    step(1);
    torque_source_cfg <= 3'h5;
    rotor_speed <= 12'h960;
    odometer <= 32'hABCD;
    amp(32'h3E8);
    step(1);
    rotor_speed <= 12'h961;
    amp(32'h0);
    chk(32'(asc_active), 32'h1);
    chk(32'(power_enable), 32'h0);
    chk(active_fault_code, 32'h1);
    step(1);
    fault_clear <= 1'b1;
    amp(32'h0);
    chk(32'(power_enable), 32'h0);
    step(1);
    rotor_speed <= 12'h0;
    wait_pe();
    fault_clear <= 1'b0;
    motor_temp <= 10'sh065;
    odometer <= 32'h0001_0000;
    amp(32'h0);
    chk(active_fault_code, 32'h2);
    step(1);
    motor_temp <= 10'sh014;
    fault_clear <= 1'b1;
    wait_pe();
    fault_clear <= 1'b0;
    rd_trace(4'h0, 32'h2, 32'h0001_0000);
    rd_trace(4'h1, 32'h1, 32'hABCD);
    rd_trace(4'h9, 32'h0, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
